// ---- common/flash_mem_if.sv ----
// Port between the serial front end and the byte array.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface flash_mem_if
    import qflash_pkg::*;
();
    logic we;
    logic re;
    logic [MEM_AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl (output we, output re, output addr, output wdata, input rdata);
    modport array (input we, input re, input addr, input wdata, output rdata);
endinterface : flash_mem_if

// ---- common/qflash_pkg.sv ----
// Constants, command codes and phase states for the serial flash slave.
// Assumes a 100 MHz system clock that oversamples the serial clock.
package qflash_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned SECT_ERASE_MS = 18;
    localparam int unsigned CHIP_ERASE_MS = 35;
    localparam int unsigned PAGE_PROG_US = 1500;
    localparam int unsigned SECT_ERASE_CYC = SECT_ERASE_MS * 1000 * CLK_MHZ;
    localparam int unsigned CHIP_ERASE_CYC = CHIP_ERASE_MS * 1000 * CLK_MHZ;
    localparam int unsigned PAGE_PROG_CYC = PAGE_PROG_US * CLK_MHZ;

    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int MEM_AW = 10;
    localparam int MEM_DEPTH = 1024;
    localparam int PAGE_AW = 8;
    localparam int BLK_LSB = 7;
    localparam int BPR_W = 8;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [4:0] ADDR_BITS = 5'h18;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [BPR_W-1:0] BPR_RESET = 8'hFF;
    localparam logic [7:0] SYNC_RESET = 8'h70;

    // ----------------------------------------
    // Lane widths and enables
    // ----------------------------------------
    localparam logic [2:0] W1 = 3'h1;
    localparam logic [2:0] W2 = 3'h2;
    localparam logic [2:0] W4 = 3'h4;
    localparam logic [3:0] OE_X1 = 4'h2;
    localparam logic [3:0] OE_X2 = 4'h3;
    localparam logic [3:0] OE_X4 = 4'hF;

    // ----------------------------------------
    // Register fields
    // ----------------------------------------
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_WEL_BIT = 1;
    localparam int ST_SUSP_BIT = 2;
    localparam int ST_QUAD_BIT = 3;
    localparam int CFG_IOC_BIT = 1;
    localparam int CFG_PIN_PROTECT_ENABLE_BIT_BIT = 7;
    localparam logic [MEM_AW-1:0] WRAP_MASK8 = 10'h007;
    localparam logic [MEM_AW-1:0] WRAP_MASK16 = 10'h00F;
    localparam logic [MEM_AW-1:0] WRAP_MASK32 = 10'h01F;
    localparam logic [MEM_AW-1:0] WRAP_MASK64 = 10'h03F;

    // ----------------------------------------
    // Commands
    // ----------------------------------------
    localparam logic [7:0] CMD_WRITE_EN = 8'h16;
    localparam logic [7:0] CMD_WRITE_DIS = 8'h14;
    localparam logic [7:0] CMD_READ_STATUS = 8'h15;
    localparam logic [7:0] CMD_READ_CONFIG = 8'h25;
    localparam logic [7:0] CMD_WRITE_CONFIG = 8'h21;
    localparam logic [7:0] CMD_READ_X1 = 8'h13;
    localparam logic [7:0] CMD_READ_X2 = 8'h1B;
    localparam logic [7:0] CMD_READ_X4 = 8'h1C;
    localparam logic [7:0] CMD_READ_WRAP = 8'h1E;
    localparam logic [7:0] CMD_SET_BURST = 8'h1F;
    localparam logic [7:0] CMD_PROG_X1 = 8'h12;
    localparam logic [7:0] CMD_PROG_X4 = 8'h32;
    localparam logic [7:0] CMD_ERASE_SECT = 8'h2E;
    localparam logic [7:0] CMD_ERASE_CHIP = 8'hC6;
    localparam logic [7:0] CMD_SUSPEND = 8'hB5;
    localparam logic [7:0] CMD_RESUME = 8'h35;
    localparam logic [7:0] CMD_QUAD_EN = 8'h38;
    localparam logic [7:0] CMD_QUAD_EXIT = 8'hFE;
    localparam logic [7:0] CMD_WRITE_BPR = 8'h42;
    localparam logic [7:0] CMD_READ_BPR = 8'h72;
    localparam logic [7:0] CMD_UNLOCK = 8'h98;

    typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_RDATA, ST_WDATA, ST_IGNORE} phase_e;

endpackage : qflash_pkg

// ---- test/flash_host_model.sv ----
// Host controller model: frames, sck, lanes; mode 0 or 3.
// Assumes the bench resolves lanes from the slave's enables.
`timescale 1ns/1ps
module flash_host_model
(
    input wire logic clock,
    output logic sck,
    output logic csN,
    output logic [3:0] hv,
    input wire logic [3:0] sioIn
);
    logic [7:0] tx [$];
    logic [7:0] rx;
    logic idleHigh = 1'b0;
    event got;
    initial
    begin
        sck = 1'b0;
        csN = 1'b1;
        hv = 4'h0;
    end
    // Data set on the fall, taken by the slave on the rise
    task automatic bit_cycle(input logic [3:0] d);
        @(negedge clock);
        sck = 1'b0;
        hv = d;
        repeat (4) @(negedge clock);
        sck = 1'b1;
        repeat (4) @(negedge clock);
    endtask : bit_cycle
    // Select held low for the whole frame
    task automatic frame(input int cw, input int dw, input int n);
        logic [7:0] s;
        int w;
        sck = idleHigh;
        repeat (2) @(negedge clock);
        csN = 1'b0;
        foreach (tx[i])
        begin
            w = i < 4 ? cw : dw;
            for (int b = 7; b >= 0; b -= w)
            begin
                s = tx[i] << (7 - b);
                bit_cycle(4'(s >> (8 - w)) | 4'($urandom << w));
            end
        end
        // Late sampling: slave output is settled well before next fall
        for (int k = 0; k < n; k++)
        begin
            for (int b = 0; b < 8; b += dw)
            begin
                bit_cycle(~hv);
                rx = (rx << dw) | 8'(dw == 1 ? sioIn[1] : sioIn & (4'hF >> (4 - dw)));
            end
            ->got;
        end
        @(negedge clock);
        sck = idleHigh;
        @(negedge clock);
        csN = 1'b1;
        repeat (6) @(negedge clock);
    endtask : frame
endmodule : flash_host_model

// ---- test/qflash_checker.sv ----
// Pin and status assertions for the serial flash slave.
// Assumes an sck half period of at least 4 system clocks.
`timescale 1ns/1ps
module qflash_checker
    import qflash_pkg::*;
#(
    parameter int unsigned CHIP_ERASE_CYCLES = 3000
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic csN,
    input wire logic pauseN,
    input wire logic [3:0] sioOut,
    input wire logic [3:0] sioOe,
    input wire logic busyFlag,
    input wire logic suspended,
    input wire logic quadMode
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    int unsigned busyCnt_q;
    // Counter, not a repetition: erase spans thousands of cycles
    always_ff @(posedge clock or posedge sys_rst)
        if (sys_rst)
            busyCnt_q <= 0;
        else
            busyCnt_q <= busyFlag ? busyCnt_q + 1 : 0;
    // ----------------------------------------
    // Sequences and assertions
    // ----------------------------------------
    sequence s_desel;
        csN [*5];
    endsequence
    sequence s_paused;
        (!pauseN && !csN && !quadMode) [*5];
    endsequence
    AST_DESEL_OFF: assert property (s_desel |-> sioOe == 4'h0)
        else $error("lanes driven while deselected");
    AST_PAUSE_OFF: assert property (s_paused |-> sioOe == 4'h0)
        else $error("lanes driven while paused");
    AST_OUT_ON_FALL: assert property ($changed(sioOut) && sioOe != 4'h0
        |-> !$past(sck) || !$past(sck, 2) || !$past(sck, 3) || !$past(sck, 4))
        else $error("read data moved away from a falling edge");
    AST_QUAD_LANES: assert property (quadMode && sioOe != 4'h0 |-> sioOe == OE_X4)
        else $error("quad mode not driving four lanes");
    AST_QUAD_IN_FRAME: assert property ($changed(quadMode) |-> !$past(csN, 3))
        else $error("lane mode changed outside a frame");
    AST_BUSY_SUSP: assert property (suspended |-> !busyFlag)
        else $error("busy shown while suspended");
    AST_SUSP_OF_BUSY: assert property ($rose(suspended) |-> $past(busyFlag))
        else $error("suspend without an operation");
    AST_ERASE_BOUND: assert property (busyCnt_q <= CHIP_ERASE_CYCLES)
        else $error("busy longer than the erase limit");
endmodule : qflash_checker

bind quad_serial_flash_bus_interface qflash_checker #(.CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES))
    chk_i (.clock(clock), .sys_rst(sys_rst), .sck(sck), .csN(csN), .pauseN(pauseN),
    .sioOut(sioOut), .sioOe(sioOe), .busyFlag(busyFlag), .suspended(suspended),
    .quadMode(quadMode));

// ---- test/testbench.sv ----
// Bench: host model drives frames, reads checked from a queue.
// Assumes shortened erase and program times below.
`timescale 1ns/1ps
module testbench
    import qflash_pkg::*;
;
    logic clock, sys_rst, wpN, pauseN, sck, csN;
    logic [3:0] hv, sioIn, sioOut, sioOe;
    logic busyFlag, suspended, quadMode, ioConfigBit, pinProtectEnableBit;
    int fail_count = 0, check_count = 0, lw = 1;
    logic [15:0] expQ [$];
    logic [7:0] d [4];
    logic [7:0] rc [3] = '{CMD_READ_X1, CMD_READ_X2, CMD_READ_X4};
    int rw [3] = '{1, 2, 4};
    assign sioIn = (sioOe & sioOut) | (~sioOe & hv);
    quad_serial_flash_bus_interface #(.SECT_ERASE_CYCLES(2000), .CHIP_ERASE_CYCLES(3000),
        .PROG_CYCLES(1500)) uut (.clock(clock), .sys_rst(sys_rst), .sck(sck), .csN(csN),
        .sioIn(sioIn), .sioOut(sioOut), .sioOe(sioOe), .wpN(wpN), .pauseN(pauseN),
        .busyFlag(busyFlag), .suspended(suspended), .quadMode(quadMode),
        .ioConfigBit(ioConfigBit), .pinProtectEnableBit(pinProtectEnableBit));
    flash_host_model host (.clock(clock), .sck(sck), .csN(csN), .hv(hv), .sioIn(sioIn));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic end_of_test();
        if (fail_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic op(input logic [7:0] c);
        host.tx = {c};
        host.frame(lw, lw, 0);
    endtask : op
    task automatic stat(input logic [15:0] e);
        expQ.push_back(e);
        host.tx = {CMD_READ_STATUS};
        host.frame(lw, lw, 1);
    endtask : stat
    task automatic cfg(input logic [7:0] v);
        op(CMD_WRITE_EN);
        host.tx = {CMD_WRITE_CONFIG, v};
        host.frame(lw, lw, 0);
    endtask : cfg
    // Two erased bytes, then the programmed ones
    task automatic rdexp(input int n);
        for (int k = 0; k < n; k++)
            expQ.push_back({8'hFF, k < 2 ? 8'hFF : d[k - 2]});
    endtask : rdexp
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        #1000000;
        fail_count++;
        end_of_test();
    end
    initial
        forever
        begin
            @(host.got);
            chk("read", expQ[0][7:0], host.rx & expQ[0][15:8]);
            void'(expQ.pop_front());
        end
    initial
    begin
        wpN = 1'b1;
        pauseN = 1'b1;
        sys_rst = 1'b1;
        void'($urandom(25038));
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        chk("oe", 8'h00, {4'h0, sioOe});
        stat(16'hFF00);
        pauseN = 1'b0;
        op(CMD_WRITE_EN);
        pauseN = 1'b1;
        stat(16'h0200);
        op(CMD_WRITE_EN);
        stat(16'hFF02);
        op(CMD_UNLOCK);
        op(CMD_WRITE_EN);
        host.tx = {CMD_ERASE_SECT, 8'h00, 8'h00, 8'h00};
        host.frame(1, 1, 0);
        stat(16'h0101);
        op(CMD_SUSPEND);
        chk("susp", 8'h01, {7'h0, suspended});
        op(CMD_RESUME);
        for (int k = 0; k < 5000 && busyFlag !== 1'b0; k++)
            @(negedge clock);
        chk("busy", 8'h00, {7'h0, busyFlag});
        op(CMD_WRITE_EN);
        host.tx = {CMD_PROG_X1, 8'h00, 8'h00, 8'h10};
        foreach (d[i])
        begin
            d[i] = 8'($urandom);
            host.tx.push_back(d[i]);
        end
        host.frame(1, 1, 0);
        for (int k = 0; k < 5000 && busyFlag !== 1'b0; k++)
            @(negedge clock);
        foreach (rc[j])
        begin
            host.tx = {rc[j], 8'h00, 8'h00, 8'h0E};
            rdexp(6);
            host.frame(1, rw[j], 6);
        end
        host.tx = {CMD_SET_BURST, 8'h00};
        host.frame(1, 1, 0);
        host.tx = {CMD_READ_WRAP, 8'h00, 8'h00, 8'h16};
        rdexp(4);
        host.frame(1, 1, 4);
        cfg(8'h80);
        wpN = 1'b0;
        cfg(8'h02);
        chk("ioc", 8'h00, {7'h0, ioConfigBit});
        wpN = 1'b1;
        cfg(8'h82);
        wpN = 1'b0;
        cfg(8'h00);
        chk("pin_protect_enable_bit", 8'h00, {7'h0, pinProtectEnableBit});
        wpN = 1'b1;
        cfg(8'h80);
        wpN = 1'b0;
        op(CMD_QUAD_EN);
        chk("quad", 8'h01, {7'h0, quadMode});
        lw = 4;
        cfg(8'h02);
        chk("ioc", 8'h01, {7'h0, ioConfigBit});
        host.tx = {CMD_READ_X4, 8'h00, 8'h00, 8'h0E};
        rdexp(6);
        host.frame(4, 4, 6);
        op(CMD_QUAD_EXIT);
        lw = 1;
        host.idleHigh = 1'b1;
        stat(16'h0800);
        end_of_test();
    end
endmodule : testbench

// ---- verilog/flash_array.sv ----
// Byte array with one port and registered read data.
// Assumes at most one access per clock; contents are undefined until written.
`timescale 1ns/1ps
module flash_array
    import qflash_pkg::*;
(
    input wire logic clock,
    flash_mem_if.array mem
);
    logic [7:0] store [0:MEM_DEPTH-1];

    always_ff @(posedge clock)
    begin
        if (mem.we)
        begin
            store[mem.addr] <= mem.wdata;
        end
        if (mem.re)
        begin
            mem.rdata <= store[mem.addr];
        end
    end
endmodule : flash_array

// ---- verilog/quad_serial_flash_bus_interface.sv ----
// Serial flash slave front end: framing, command decode, x1/x2/x4 lanes.
// Assumes serial clock half period of at least 3 system clocks.
`timescale 1ns/1ps
module quad_serial_flash_bus_interface
    import qflash_pkg::*;
#(
    parameter int unsigned SECT_ERASE_CYCLES = SECT_ERASE_CYC,
    parameter int unsigned CHIP_ERASE_CYCLES = CHIP_ERASE_CYC,
    parameter int unsigned PROG_CYCLES = PAGE_PROG_CYC
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic csN,
    input wire logic [3:0] sioIn,
    output logic [3:0] sioOut,
    output logic [3:0] sioOe,
    input wire logic wpN,
    input wire logic pauseN,
    output logic busyFlag,
    output logic suspended,
    output logic quadMode,
    output logic ioConfigBit,
    output logic pinProtectEnableBit
);
    // ----------------------------------------
    // Pin synchronisers and edges
    // ----------------------------------------
    logic [7:0] syncA_q;
    logic [7:0] syncB_q;
    logic sckPrev_q;
    logic csPrev_q;
    logic sckS, csS, wpS, pauseS;
    logic [3:0] sioS;

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            syncA_q <= SYNC_RESET;
            syncB_q <= SYNC_RESET;
            sckPrev_q <= 1'b0;
            csPrev_q <= 1'b1;
        end
        else
        begin
            syncA_q <= {sck, csN, wpN, pauseN, sioIn};
            syncB_q <= syncA_q;
            sckPrev_q <= sckS;
            csPrev_q <= csS;
        end
    end

    assign {sckS, csS, wpS, pauseS, sioS} = syncB_q;

    // Edges found by level compare, so either idle clock level works
    logic sckRise, sckFall, csFall, csRise;
    assign sckRise = sckS & ~sckPrev_q;
    assign sckFall = ~sckS & sckPrev_q;
    assign csFall = ~csS & csPrev_q;
    assign csRise = csS & ~csPrev_q;

    // ----------------------------------------
    // State declarations
    // ----------------------------------------
    phase_e phase_q;
    logic selected_q, addrDone_q, wrote_q, drv_q;
    logic [4:0] bitCnt_q;
    logic [23:0] inSh_q;
    logic [7:0] cmd_q;
    logic [MEM_AW-1:0] addr_q;
    logic [7:0] outSh_q;
    logic [3:0] outCnt_q;
    logic quad_q, wel_q, ioc_q, pin_protect_enable_bit_q;
    logic [BPR_W-1:0] bpr_q;
    logic [1:0] wrapSel_q;
    logic busy_q, susp_q;
    logic [31:0] busyCnt_q;
    logic sweepOn_q;
    logic [MEM_AW-1:0] sweepPtr_q, sweepLast_q;

    flash_mem_if memBus ();

    flash_array array (
        .clock(clock),
        .mem(memBus)
    );

    // ----------------------------------------
    // Command classes and lane widths
    // ----------------------------------------
    function automatic logic isMemRead(input logic [7:0] c);
        return (c == CMD_READ_X1) || (c == CMD_READ_X2) || (c == CMD_READ_X4)
            || (c == CMD_READ_WRAP);
    endfunction : isMemRead

    function automatic logic isProg(input logic [7:0] c);
        return (c == CMD_PROG_X1) || (c == CMD_PROG_X4);
    endfunction : isProg

    function automatic logic isErase(input logic [7:0] c);
        return (c == CMD_ERASE_SECT) || (c == CMD_ERASE_CHIP);
    endfunction : isErase

    function automatic phase_e afterCmd(input logic [7:0] c);
        phase_e p;
        p = ST_IGNORE;
        if (isMemRead(c) || isProg(c) || isErase(c))
            p = ST_ADDR;
        else if ((c == CMD_READ_STATUS) || (c == CMD_READ_CONFIG) || (c == CMD_READ_BPR))
            p = ST_RDATA;
        else if ((c == CMD_WRITE_CONFIG) || (c == CMD_WRITE_BPR) || (c == CMD_SET_BURST))
            p = ST_WDATA;
        return p;
    endfunction : afterCmd

    logic [2:0] cmdW, dataW, phaseW;
    always_comb
    begin
        cmdW = quad_q ? W4 : W1;
        dataW = W1;
        if (quad_q)
            dataW = W4;
        else if (cmd_q == CMD_READ_X2)
            dataW = W2;
        else if ((cmd_q == CMD_READ_X4) || (cmd_q == CMD_PROG_X4))
            dataW = W4;
        phaseW = ((phase_q == ST_CMD) || (phase_q == ST_ADDR)) ? cmdW : dataW;
    end

    logic [23:0] shIn;
    logic [4:0] bitsNow;
    always_comb
    begin
        case (phaseW)
            W4: shIn = {inSh_q[19:0], sioS};
            W2: shIn = {inSh_q[21:0], sioS[1:0]};
            default: shIn = {inSh_q[22:0], sioS[0]};
        endcase
        bitsNow = bitCnt_q + {2'b00, phaseW};
    end

    // ----------------------------------------
    // Events and protection
    // ----------------------------------------
    logic paused, live, riseNow, cmdDone, addrDoneNow, byteDone, loadNow;
    logic wpBlock, progOk, frameEnd, progStart, eraseStart;
    logic [MEM_AW-1:0] wrapMask, readNext;

    assign paused = ~pauseS & ~quad_q;
    assign live = selected_q & ~csS & ~paused;
    assign riseNow = live & sckRise;
    assign cmdDone = riseNow & (phase_q == ST_CMD) & (bitsNow == BYTE_BITS);
    assign addrDoneNow = riseNow & (phase_q == ST_ADDR) & (bitsNow == ADDR_BITS);
    assign byteDone = riseNow & (phase_q == ST_WDATA) & (bitsNow == BYTE_BITS);
    assign loadNow = live & sckFall & (phase_q == ST_RDATA) & (outCnt_q == 4'h0);
    // Pin ignored in quad mode or with io-config set
    assign wpBlock = ~ioc_q & pin_protect_enable_bit_q & ~wpS & ~quad_q;
    assign progOk = isProg(cmd_q) & wel_q & ~busy_q & ~susp_q
        & ~bpr_q[addr_q[MEM_AW-1:BLK_LSB]];
    assign frameEnd = csRise & selected_q;
    assign progStart = frameEnd & isProg(cmd_q) & wrote_q;
    assign eraseStart = frameEnd & isErase(cmd_q) & addrDone_q & wel_q & ~busy_q & ~susp_q;

    always_comb
    begin
        case (wrapSel_q)
            2'h0: wrapMask = WRAP_MASK8;
            2'h1: wrapMask = WRAP_MASK16;
            2'h2: wrapMask = WRAP_MASK32;
            default: wrapMask = WRAP_MASK64;
        endcase
        if (cmd_q == CMD_READ_WRAP)
            readNext = (addr_q & ~wrapMask) | ((addr_q + 10'h001) & wrapMask);
        else
            readNext = addr_q + 10'h001;
    end

    // ----------------------------------------
    // Framing and input phases
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            phase_q <= ST_CMD;
            selected_q <= 1'b0;
            bitCnt_q <= '0;
            inSh_q <= '0;
            cmd_q <= '0;
            addr_q <= '0;
            addrDone_q <= 1'b0;
            wrote_q <= 1'b0;
        end
        else if (csFall)
        begin
            selected_q <= 1'b1;
            phase_q <= ST_CMD;
            cmd_q <= '0;
            bitCnt_q <= '0;
            addrDone_q <= 1'b0;
            wrote_q <= 1'b0;
        end
        else if (csS)
        begin
            selected_q <= 1'b0;
            phase_q <= ST_CMD;
            bitCnt_q <= '0;
        end
        else if (riseNow)
        begin
            inSh_q <= shIn;
            bitCnt_q <= bitsNow;
            if (cmdDone)
            begin
                bitCnt_q <= '0;
                cmd_q <= shIn[7:0];
                phase_q <= afterCmd(shIn[7:0]);
            end
            else if (addrDoneNow)
            begin
                bitCnt_q <= '0;
                addr_q <= shIn[MEM_AW-1:0];
                addrDone_q <= 1'b1;
                if (isMemRead(cmd_q))
                    phase_q <= ST_RDATA;
                else if (isProg(cmd_q))
                    phase_q <= ST_WDATA;
                else
                    phase_q <= ST_IGNORE;
            end
            else if (byteDone)
            begin
                bitCnt_q <= '0;
                if (progOk)
                begin
                    // Address wraps inside the page
                    addr_q <= {addr_q[MEM_AW-1:PAGE_AW], addr_q[PAGE_AW-1:0] + 8'h01};
                    wrote_q <= 1'b1;
                end
            end
        end
        else if (loadNow && isMemRead(cmd_q))
        begin
            addr_q <= readNext;
        end
    end

    // ----------------------------------------
    // Read data output
    // ----------------------------------------
    logic [7:0] statusByte, cfgByte, srcByte, nextSh;
    logic [3:0] laneMask;
    always_comb
    begin
        statusByte = '0;
        statusByte[ST_BUSY_BIT] = busy_q & ~susp_q;
        statusByte[ST_WEL_BIT] = wel_q;
        statusByte[ST_SUSP_BIT] = susp_q;
        statusByte[ST_QUAD_BIT] = quad_q;
        cfgByte = '0;
        cfgByte[CFG_IOC_BIT] = ioc_q;
        cfgByte[CFG_PIN_PROTECT_ENABLE_BIT_BIT] = pin_protect_enable_bit_q;
        if (cmd_q == CMD_READ_STATUS)
            srcByte = statusByte;
        else if (cmd_q == CMD_READ_CONFIG)
            srcByte = cfgByte;
        else if (cmd_q == CMD_READ_BPR)
            srcByte = bpr_q;
        else
            srcByte = memBus.rdata;
        nextSh = (outCnt_q == 4'h0) ? srcByte : outSh_q;
        case (dataW)
            W4: laneMask = OE_X4;
            W2: laneMask = OE_X2;
            default: laneMask = OE_X1;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            outSh_q <= '0;
            outCnt_q <= '0;
            sioOut <= '0;
            drv_q <= 1'b0;
        end
        else if (csS)
        begin
            outCnt_q <= '0;
            drv_q <= 1'b0;
        end
        else if (live && sckFall && (phase_q == ST_RDATA))
        begin
            drv_q <= 1'b1;
            outCnt_q <= (outCnt_q == 4'h0) ? 4'(8 - dataW) : 4'(outCnt_q - dataW);
            case (dataW)
                W4:
                begin
                    sioOut <= nextSh[7:4];
                    outSh_q <= {nextSh[3:0], 4'h0};
                end
                W2:
                begin
                    sioOut <= {2'b00, nextSh[7:6]};
                    outSh_q <= {nextSh[5:0], 2'b00};
                end
                default:
                begin
                    sioOut <= {2'b00, nextSh[7], 1'b0};
                    outSh_q <= {nextSh[6:0], 1'b0};
                end
            endcase
        end
    end

    // Outputs released while paused or deselected
    assign sioOe = (drv_q && live) ? laneMask : 4'h0;

    // ----------------------------------------
    // Mode and protection registers
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            quad_q <= 1'b0;
            wel_q <= 1'b0;
            ioc_q <= 1'b0;
            pin_protect_enable_bit_q <= 1'b0;
            bpr_q <= BPR_RESET;
            wrapSel_q <= '0;
        end
        else if (cmdDone)
        begin
            case (shIn[7:0])
                CMD_WRITE_EN: wel_q <= 1'b1;
                CMD_WRITE_DIS: wel_q <= 1'b0;
                CMD_QUAD_EN: quad_q <= 1'b1;
                CMD_QUAD_EXIT: quad_q <= 1'b0;
                CMD_UNLOCK:
                begin
                    if (wel_q && !wpBlock)
                        bpr_q <= '0;
                    wel_q <= 1'b0;
                end
                default: wel_q <= wel_q;
            endcase
        end
        else if (byteDone)
        begin
            if (cmd_q == CMD_SET_BURST)
                wrapSel_q <= shIn[1:0];
            else if (cmd_q == CMD_WRITE_BPR && wel_q && !wpBlock)
                bpr_q <= shIn[BPR_W-1:0];
            else if (cmd_q == CMD_WRITE_CONFIG && wel_q && !wpBlock)
            begin
                ioc_q <= shIn[CFG_IOC_BIT];
                pin_protect_enable_bit_q <= shIn[CFG_PIN_PROTECT_ENABLE_BIT_BIT];
            end
        end
        else if (frameEnd)
        begin
            if (isProg(cmd_q) || isErase(cmd_q) || (cmd_q == CMD_WRITE_BPR)
                || (cmd_q == CMD_WRITE_CONFIG))
                wel_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Busy timer and suspend
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_q <= 1'b0;
            susp_q <= 1'b0;
            busyCnt_q <= '0;
        end
        else if (progStart || eraseStart)
        begin
            busy_q <= 1'b1;
            if (progStart)
                busyCnt_q <= PROG_CYCLES - 1;
            else if (cmd_q == CMD_ERASE_CHIP)
                busyCnt_q <= CHIP_ERASE_CYCLES - 1;
            else
                busyCnt_q <= SECT_ERASE_CYCLES - 1;
        end
        else if (cmdDone && shIn[7:0] == CMD_SUSPEND && busy_q)
            susp_q <= 1'b1;
        else if (cmdDone && shIn[7:0] == CMD_RESUME)
            susp_q <= 1'b0;
        else if (busy_q && !susp_q)
        begin
            if (busyCnt_q != 32'h0)
                busyCnt_q <= busyCnt_q - 32'h1;
            else if (!sweepOn_q)
                busy_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Array port and erase sweep
    // ----------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            memBus.we <= 1'b0;
            memBus.re <= 1'b0;
            memBus.addr <= '0;
            memBus.wdata <= '0;
            sweepOn_q <= 1'b0;
            sweepPtr_q <= '0;
            sweepLast_q <= '0;
        end
        else
        begin
            memBus.we <= 1'b0;
            memBus.re <= 1'b0;
            // Frame traffic wins; sweep only loses a cycle
            if (addrDoneNow && isMemRead(cmd_q))
            begin
                memBus.re <= 1'b1;
                memBus.addr <= shIn[MEM_AW-1:0];
            end
            else if (loadNow && isMemRead(cmd_q))
            begin
                memBus.re <= 1'b1;
                memBus.addr <= readNext;
            end
            else if (byteDone && progOk)
            begin
                memBus.we <= 1'b1;
                memBus.addr <= addr_q;
                memBus.wdata <= shIn[7:0];
            end
            else if (sweepOn_q && busy_q && !susp_q)
            begin
                memBus.we <= ~bpr_q[sweepPtr_q[MEM_AW-1:BLK_LSB]];
                memBus.addr <= sweepPtr_q;
                memBus.wdata <= ERASED_BYTE;
                sweepPtr_q <= sweepPtr_q + 10'h001;
                if (sweepPtr_q == sweepLast_q)
                    sweepOn_q <= 1'b0;
            end
            if (eraseStart)
            begin
                sweepOn_q <= 1'b1;
                if (cmd_q == CMD_ERASE_SECT)
                begin
                    sweepPtr_q <= {addr_q[MEM_AW-1:PAGE_AW], 8'h00};
                    sweepLast_q <= {addr_q[MEM_AW-1:PAGE_AW], 8'hFF};
                end
                else
                begin
                    sweepPtr_q <= '0;
                    sweepLast_q <= '1;
                end
            end
        end
    end

    assign busyFlag = busy_q & ~susp_q;
    assign suspended = susp_q;
    assign quadMode = quad_q;
    assign ioConfigBit = ioc_q;
    assign pinProtectEnableBit = pin_protect_enable_bit_q;
endmodule : quad_serial_flash_bus_interface
